// [verilog/twe_map.svh]
// Purpose: Register offsets, field positions, reset values, status codes and timing.
// Assumes: Included by the two-wire event handshake design files.
// Notes: Status codes sit in bits 7:3; the low three bits always read zero.
`ifndef TWE_MAP_SVH
`define TWE_MAP_SVH

`define TWE_OFS_CTRL 5'h00
`define TWE_OFS_STATUS 5'h04
`define TWE_OFS_DATA 5'h08
`define TWE_OFS_OWN 5'h0C

`define TWE_CB_FLAG 7
`define TWE_CB_ACKEN 6
`define TWE_CB_STA 5
`define TWE_CB_STO 4
`define TWE_CB_EN 2
`define TWE_CB_IE 0
`define TWE_OB_GCE 0

`define TWE_RST_OWN 8'h00
`define TWE_RST_DATA 8'hFF

`define TWE_SC_BUSERR 8'h00
`define TWE_SC_START 8'h08
`define TWE_SC_RSTART 8'h10
`define TWE_SC_MT_SLA_ACK 8'h18
`define TWE_SC_MT_SLA_NACK 8'h20
`define TWE_SC_MT_DAT_ACK 8'h28
`define TWE_SC_MT_DAT_NACK 8'h30
`define TWE_SC_ARB_LOST 8'h38
`define TWE_SC_MR_SLA_ACK 8'h40
`define TWE_SC_MR_SLA_NACK 8'h48
`define TWE_SC_MR_DAT_ACK 8'h50
`define TWE_SC_MR_DAT_NACK 8'h58
`define TWE_SC_SR_SLA 8'h60
`define TWE_SC_SR_GC 8'h70
`define TWE_SC_SR_DAT_ACK 8'h80
`define TWE_SC_SR_DAT_NACK 8'h88
`define TWE_SC_SR_GC_ACK 8'h90
`define TWE_SC_SR_GC_NACK 8'h98
`define TWE_SC_SR_STOP 8'hA0
`define TWE_SC_ST_SLA 8'hA8
`define TWE_SC_ST_DAT_ACK 8'hB8
`define TWE_SC_ST_DAT_NACK 8'hC0
`define TWE_SC_NONE 8'hF8

`define TWE_CLK_MHZ 40
`define TWE_SCL_HALF_NS 5000
`define TWE_SCL_HALF_CYC ((`TWE_SCL_HALF_NS * `TWE_CLK_MHZ + 999) / 1000)

`endif

// [verilog/twe_pkg.sv]
// Purpose: Types shared by the two-wire event handshake design.
// Assumes: Constants come from twe_map.svh.
// Notes: All state of each module is one packed struct.
package twe_pkg;

   typedef enum logic [2:0] {TWE_IDLE, TWE_START, TWE_XFER, TWE_HOLD, TWE_STOP} twe_state_e;

   typedef struct packed {
      logic scl_p;
      logic sda_p;
   } twe_det_s;

   typedef struct packed {
      twe_state_e st;
      logic [1:0] ph;
      logic [15:0] cnt;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic rxb;
      logic master;
      logic slave;
      logic tx;
      logic addr_ph;
      logic gc;
      logic rw;
      logic rs;
      logic pend;
      logic quit;
      logic ack_drv;
      logic mlow;
      logic sda_low;
      logic flag;
      logic [7:0] code;
      logic [7:0] status;
      logic ack_en;
      logic sta;
      logic sto;
      logic en;
      logic ie;
      logic [6:0] own;
      logic gce;
      logic busy;
      logic scl_p;
      logic wb_ack;
      logic [31:0] wb_dat;
      logic irq;
      logic scl_oe;
      logic sda_oe;
      logic scl_o;
      logic sda_o;
   } twe_core_s;

endpackage : twe_pkg

// [verilog/twe_sync.sv]
// Purpose: Two-stage synchroniser for the bus pins.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes: The first stage feeds the second stage only.
`timescale 1ns/1ps
module twe_sync #(
   parameter int W = 2
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } twe_sync_s;

   twe_sync_s s_q;
   twe_sync_s s_d;

   always_comb begin
      s_d.s1 = din;
      s_d.s2 = s_q.s1;
   end

   // Idle open-drain lines float high, so reset to high avoids false edges.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.s2;
endmodule : twe_sync

// [verilog/twe_cond_det.sv]
// Purpose: Finds START and STOP conditions on the synchronised lines.
// Assumes: Both inputs already passed the synchroniser.
// Notes: Outputs are one-cycle pulses.
`timescale 1ns/1ps
module twe_cond_det (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic scl_s,
   input wire logic sda_s,
   output logic start_det,
   output logic stop_det
);
   twe_pkg::twe_det_s s_q;
   twe_pkg::twe_det_s s_d;

   always_comb begin
      s_d.scl_p = scl_s;
      s_d.sda_p = sda_s;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign start_det = scl_s & s_q.scl_p & s_q.sda_p & ~sda_s;
   assign stop_det = scl_s & s_q.scl_p & ~s_q.sda_p & sda_s;
endmodule : twe_cond_det

// [verilog/twe_top.sv]
// Purpose: Event-flag control unit of a byte-wide two-wire serial interface.
// Assumes: Classic Wishbone slave on sys_clk; bus pins are open drain.
// Notes: Bit rate, own address match detail and slave arbitration recovery are minimal.
`timescale 1ns/1ps
`include "twe_map.svh"
module twe_top #(
   parameter int HALF_CYC = `TWE_SCL_HALF_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic cpu_gie,
   output logic irq_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);

   twe_pkg::twe_core_s s;
   twe_pkg::twe_core_s n;

   logic scl_s;
   logic sda_s;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;
   logic tdone;
   logic acc;
   logic wr;
   logic go;
   logic set;
   logic ackd;
   logic match;
   logic [7:0] ncode;
   logic [7:0] nsh;
   logic [15:0] tick;

   function automatic logic hit(input logic [4:0] adr, input logic [4:0] ofs);
      return {adr[4:2], 2'h0} == ofs;
   endfunction : hit

   twe_sync #(.W(2)) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .din({scl_i, sda_i}),
      .dout({scl_s, sda_s})
   );

   twe_cond_det u_det (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .start_det(start_det),
      .stop_det(stop_det)
   );

   always_comb begin
      n = s;
      set = 1'b0;
      ncode = s.code;
      nsh = {s.sh[6:0], s.rxb};
      ackd = ~s.rxb;
      match = (nsh[7:1] == s.own) || (s.gce && nsh[7:1] == 7'h00);
      scl_rise = scl_s & ~s.scl_p;
      scl_fall = ~scl_s & s.scl_p;
      tdone = (s.cnt == HALF_M1);
      tick = tdone ? 16'h0 : s.cnt + 16'h1;
      acc = wb_cyc_i & wb_stb_i & ~s.wb_ack;
      wr = acc & wb_we_i & wb_sel_i[0];
      go = wr & hit(wb_adr_i, `TWE_OFS_CTRL) & wb_dat_i[`TWE_CB_FLAG];
      n.scl_p = scl_s;
      n.wb_ack = acc;
      if (acc) begin
         n.wb_dat = 32'h0;
         if (hit(wb_adr_i, `TWE_OFS_CTRL)) begin
            n.wb_dat[7:0] = {s.flag, s.ack_en, s.sta, s.sto, 1'b0, s.en, 1'b0, s.ie};
         end else if (hit(wb_adr_i, `TWE_OFS_STATUS)) begin
            n.wb_dat[7:0] = s.status;
         end else if (hit(wb_adr_i, `TWE_OFS_DATA)) begin
            n.wb_dat[7:0] = s.sh;
         end else if (hit(wb_adr_i, `TWE_OFS_OWN)) begin
            n.wb_dat[7:0] = {s.own, s.gce};
         end
      end
      if (wr && hit(wb_adr_i, `TWE_OFS_CTRL)) begin
         n.ack_en = wb_dat_i[`TWE_CB_ACKEN];
         n.sta = wb_dat_i[`TWE_CB_STA];
         n.sto = wb_dat_i[`TWE_CB_STO];
         n.en = wb_dat_i[`TWE_CB_EN];
         n.ie = wb_dat_i[`TWE_CB_IE];
      end
      // The shift register is moving mid-byte, so writes only land while the flag is set or the unit is idle.
      if (wr && hit(wb_adr_i, `TWE_OFS_DATA) && (s.flag || s.st == twe_pkg::TWE_IDLE)) begin
         n.sh = wb_dat_i[7:0];
      end
      if (wr && hit(wb_adr_i, `TWE_OFS_OWN)) begin
         n.own = wb_dat_i[7:1];
         n.gce = wb_dat_i[`TWE_OB_GCE];
      end
      if (start_det) begin
         n.busy = 1'b1;
      end else if (stop_det) begin
         n.busy = 1'b0;
      end

      unique case (s.st)
         twe_pkg::TWE_IDLE: begin
            n.mlow = 1'b0;
            n.sda_low = 1'b0;
            if (go && n.sta) begin
               n.pend = 1'b1;
            end
            if (s.pend && !s.busy) begin
               n.st = twe_pkg::TWE_START;
               n.ph = 2'h2;
               n.cnt = 16'h0;
               n.rs = 1'b0;
               n.pend = 1'b0;
            end else if (start_det) begin
               n.st = twe_pkg::TWE_XFER;
               n.master = 1'b0;
               n.slave = 1'b0;
               n.tx = 1'b0;
               n.addr_ph = 1'b1;
               n.bitn = 4'h0;
            end
         end
         twe_pkg::TWE_START: begin
            unique case (s.ph)
               2'h0: begin
                  n.mlow = 1'b1;
                  n.sda_low = 1'b0;
                  n.cnt = tick;
                  if (tdone) begin
                     n.ph = 2'h1;
                  end
               end
               2'h1: begin
                  n.mlow = 1'b0;
                  if (scl_s) begin
                     n.cnt = tick;
                     if (tdone) begin
                        n.ph = 2'h2;
                     end
                  end
               end
               default: begin
                  n.sda_low = 1'b1;
                  n.cnt = tick;
                  if (tdone) begin
                     n.mlow = 1'b1;
                     set = 1'b1;
                     ncode = s.rs ? `TWE_SC_RSTART : `TWE_SC_START;
                     n.st = twe_pkg::TWE_HOLD;
                     n.master = 1'b1;
                     n.slave = 1'b0;
                     n.tx = 1'b1;
                     n.addr_ph = 1'b1;
                  end
               end
            endcase
         end
         twe_pkg::TWE_XFER: begin
            if (start_det || stop_det) begin
               n.sda_low = 1'b0;
               n.mlow = 1'b0;
               if (s.slave && s.bitn == 4'h0) begin
                  set = 1'b1;
                  ncode = `TWE_SC_SR_STOP;
                  n.quit = 1'b1;
                  n.st = twe_pkg::TWE_HOLD;
               end else if (!s.master && s.addr_ph && s.bitn == 4'h0) begin
                  n.st = stop_det ? twe_pkg::TWE_IDLE : twe_pkg::TWE_XFER;
               end else begin
                  set = 1'b1;
                  ncode = `TWE_SC_BUSERR;
                  n.quit = 1'b1;
                  n.master = 1'b0;
                  n.st = twe_pkg::TWE_HOLD;
               end
            end else begin
               if (s.master) begin
                  if (s.mlow || scl_s) begin
                     n.cnt = tick;
                     if (tdone) begin
                        n.mlow = ~s.mlow;
                     end
                  end
               end
               if (s.bitn[3]) begin
                  n.sda_low = ~s.tx & s.ack_drv;
               end else begin
                  n.sda_low = s.tx & ~s.sh[7];
               end
               if (scl_rise) begin
                  n.rxb = sda_s;
                  if (s.master && s.tx && !s.bitn[3] && s.sh[7] && !sda_s) begin
                     set = 1'b1;
                     ncode = `TWE_SC_ARB_LOST;
                     n.master = 1'b0;
                     n.quit = 1'b1;
                     n.sda_low = 1'b0;
                     n.mlow = 1'b0;
                     n.st = twe_pkg::TWE_HOLD;
                  end
               end else if (scl_fall && !s.bitn[3]) begin
                  n.sh = nsh;
                  n.bitn = s.bitn + 4'h1;
                  if (s.bitn == 4'h7) begin
                     n.rw = s.addr_ph ? nsh[0] : s.rw;
                     if (s.addr_ph && !s.master) begin
                        n.ack_drv = match & s.ack_en;
                        n.gc = nsh[7:1] == 7'h00;
                     end
                  end
               end else if (scl_fall) begin
                  n.bitn = 4'h0;
                  n.addr_ph = 1'b0;
                  n.sda_low = 1'b0;
                  n.mlow = s.master;
                  n.st = twe_pkg::TWE_HOLD;
                  set = 1'b1;
                  if (s.master && s.addr_ph) begin
                     n.tx = ~s.rw;
                     if (s.rw) begin
                        ncode = ackd ? `TWE_SC_MR_SLA_ACK : `TWE_SC_MR_SLA_NACK;
                     end else begin
                        ncode = ackd ? `TWE_SC_MT_SLA_ACK : `TWE_SC_MT_SLA_NACK;
                     end
                  end else if (s.master && s.tx) begin
                     ncode = ackd ? `TWE_SC_MT_DAT_ACK : `TWE_SC_MT_DAT_NACK;
                  end else if (s.master) begin
                     ncode = s.ack_drv ? `TWE_SC_MR_DAT_ACK : `TWE_SC_MR_DAT_NACK;
                  end else if (s.addr_ph) begin
                     if (s.ack_drv) begin
                        n.slave = 1'b1;
                        n.tx = s.rw;
                        ncode = s.rw ? `TWE_SC_ST_SLA : (s.gc ? `TWE_SC_SR_GC : `TWE_SC_SR_SLA);
                     end else begin
                        set = 1'b0;
                        n.st = twe_pkg::TWE_IDLE;
                     end
                  end else if (s.tx) begin
                     ncode = ackd ? `TWE_SC_ST_DAT_ACK : `TWE_SC_ST_DAT_NACK;
                     n.quit = ~ackd;
                  end else if (s.gc) begin
                     ncode = s.ack_drv ? `TWE_SC_SR_GC_ACK : `TWE_SC_SR_GC_NACK;
                  end else begin
                     ncode = s.ack_drv ? `TWE_SC_SR_DAT_ACK : `TWE_SC_SR_DAT_NACK;
                  end
               end
            end
         end
         twe_pkg::TWE_HOLD: begin
            // Parked with the clock held; only the flag-clearing write or a write clearing the enable bit moves on.
            if (go) begin
               n.cnt = 16'h0;
               n.bitn = 4'h0;
               if (s.quit) begin
                  n.st = twe_pkg::TWE_IDLE;
                  n.quit = 1'b0;
                  n.master = 1'b0;
                  n.slave = 1'b0;
               end else if (n.sta && s.master) begin
                  n.st = twe_pkg::TWE_START;
                  n.ph = 2'h0;
                  n.rs = 1'b1;
               end else if (n.sto && s.master) begin
                  n.st = twe_pkg::TWE_STOP;
                  n.ph = 2'h0;
               end else if (s.master || s.slave) begin
                  n.st = twe_pkg::TWE_XFER;
                  n.ack_drv = n.ack_en;
               end else begin
                  n.st = twe_pkg::TWE_IDLE;
               end
            end
         end
         twe_pkg::TWE_STOP: begin
            unique case (s.ph)
               2'h0: begin
                  n.mlow = 1'b1;
                  n.sda_low = 1'b1;
                  n.cnt = tick;
                  if (tdone) begin
                     n.ph = 2'h1;
                  end
               end
               2'h1: begin
                  n.mlow = 1'b0;
                  if (scl_s) begin
                     n.cnt = tick;
                     if (tdone) begin
                        n.ph = 2'h2;
                     end
                  end
               end
               default: begin
                  n.sda_low = 1'b0;
                  n.cnt = tick;
                  if (tdone) begin
                     n.st = twe_pkg::TWE_IDLE;
                     n.master = 1'b0;
                  end
               end
            endcase
         end
         default: begin
            n.st = twe_pkg::TWE_IDLE;
         end
      endcase

      n.flag = (s.flag & ~go) | set;
      if (set) begin
         n.code = ncode;
      end
      n.status = s.flag ? s.code : `TWE_SC_NONE;
      if (!n.en) begin
         n.st = twe_pkg::TWE_IDLE;
         n.mlow = 1'b0;
         n.sda_low = 1'b0;
         n.master = 1'b0;
         n.slave = 1'b0;
         n.pend = 1'b0;
         n.quit = 1'b0;
      end
      n.irq = s.flag & s.ie & cpu_gie;
      n.scl_oe = n.flag | n.mlow;
      n.sda_oe = n.sda_low;
      n.scl_o = 1'b0;
      n.sda_o = 1'b0;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
         s.st <= twe_pkg::TWE_IDLE;
         s.sh <= `TWE_RST_DATA;
         s.own <= 7'(`TWE_RST_OWN >> 1);
         s.status <= `TWE_SC_NONE;
         s.scl_p <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign wb_dat_o = s.wb_dat;
   assign wb_ack_o = s.wb_ack;
   assign irq_o = s.irq;
   assign scl_oe = s.scl_oe;
   assign sda_oe = s.sda_oe;
   assign scl_o = s.scl_o;
   assign sda_o = s.sda_o;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   property p_scl_hold;
      s.flag |-> s.scl_oe;
   endproperty
   a_scl_hold: assert property (p_scl_hold) else $error("clock line not held while flag set");

   property p_start_flag;
      (s.st == twe_pkg::TWE_START ##1 s.st == twe_pkg::TWE_HOLD) |->
         s.flag && (s.code == `TWE_SC_START || s.code == `TWE_SC_RSTART);
   endproperty
   a_start_flag: assert property (p_start_flag) else $error("start done without flag");

   property p_arb_flag;
      ($fell(s.master) && s.st == twe_pkg::TWE_HOLD) |-> s.flag && s.code != `TWE_SC_NONE;
   endproperty
   a_arb_flag: assert property (p_arb_flag) else $error("lost master role without flag");

   property p_status_next;
      $rose(s.flag) |=> s.status == $past(s.code);
   endproperty
   a_status_next: assert property (p_status_next) else $error("status not loaded after flag");

   property p_status_none;
      !s.flag |=> s.status == `TWE_SC_NONE;
   endproperty
   a_status_none: assert property (p_status_none) else $error("status not idle code");

   property p_no_op;
      (s.st == twe_pkg::TWE_HOLD && s.flag && !go) |=> s.st == twe_pkg::TWE_HOLD && s.flag;
   endproperty
   a_no_op: assert property (p_no_op) else $error("operation began with flag set");

   property p_go;
      (s.st == twe_pkg::TWE_HOLD && go && s.en && n.en) |=>
         !s.flag && s.st != twe_pkg::TWE_HOLD;
   endproperty
   a_go: assert property (p_go) else $error("flag clear did not start action");

   property p_zero_keep;
      (s.flag && wr && hit(wb_adr_i, `TWE_OFS_CTRL) && !wb_dat_i[`TWE_CB_FLAG]) |=> s.flag;
   endproperty
   a_zero_keep: assert property (p_zero_keep) else $error("zero write cleared flag");

   property p_stop_quiet;
      s.st == twe_pkg::TWE_STOP |=> !s.flag;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("flag set around stop");

   property p_irq;
      (s.flag && s.ie && cpu_gie) |=> s.irq ##1 (s.irq || !$past(s.flag && s.ie && cpu_gie));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

   property p_irq_off;
      !(s.flag && s.ie && cpu_gie) |=> !s.irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");

   c_start: cover property (s.st == twe_pkg::TWE_START ##1 s.st == twe_pkg::TWE_HOLD);
   c_slave: cover property ($rose(s.slave));
   c_buserr: cover property ($rose(s.flag) && s.code == `TWE_SC_BUSERR);
   c_stop: cover property (s.st == twe_pkg::TWE_STOP ##1 s.st == twe_pkg::TWE_IDLE);
endmodule : twe_top

// [dv/twe_slave.sv]
// Purpose: Behavioural slave on the two-wire bus.
// Assumes: Open-drain lines with pull-ups; the master drives the clock line.
// Notes: Pulls the data line only in the ack slot, so a released line reads high.
`timescale 1ns/1ps
module twe_slave (
   input wire logic scl,
   input wire logic sda,
   input wire logic ack_en,
   output logic sda_pull,
   output logic [7:0] last_byte,
   output logic stop_seen
);
   int bitc = 0;
   logic [7:0] sh = 8'h00;
   initial begin
      sda_pull = 1'b0;
      last_byte = 8'h00;
      stop_seen = 1'b0;
   end
   always @(negedge sda) begin
      if (scl) begin
         bitc = 0;
         stop_seen = 1'b0;
      end
   end
   always @(posedge sda) begin
      if (scl) begin
         stop_seen = 1'b1;
      end
   end
   always @(posedge scl) begin
      if (bitc < 8) begin
         sh = {sh[6:0], sda};
      end
      bitc = bitc + 1;
   end
   // The ack is driven and released on falling clock edges so it never looks like a condition.
   always @(negedge scl) begin
      if (bitc == 8) begin
         sda_pull = ack_en;
      end else if (bitc == 9) begin
         sda_pull = 1'b0;
         last_byte = sh;
         bitc = 0;
      end
   end
endmodule : twe_slave

// [dv/tb.sv]
// Purpose: Self-checking bench for the two-wire event handshake.
// Assumes: Short half period so a byte takes about 165 clocks.
// Notes: A half period of 8 leaves the data line settled well before the clock rises.
// Notes: Registers are reached over classic Wishbone single cycles.
`timescale 1ns/1ps
`include "twe_map.svh"
module tb;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_we = 1'b0;
   logic [4:0] wb_adr = 5'h00;
   logic [31:0] wb_wdat = 32'h0;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic cpu_gie = 1'b1;
   logic ack_en = 1'b1;
   logic irq, scl_o, scl_oe, sda_o, sda_oe, sda_pull, stop_seen;
   logic [7:0] last_byte;
   logic [31:0] rd = 32'h0;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   wire scl_line = !scl_oe;
   wire sda_line = !(sda_oe || sda_pull);
   always #12.5 sys_clk = ~sys_clk;
   twe_top #(.HALF_CYC(8)) twe_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .cpu_gie(cpu_gie), .irq_o(irq), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
   twe_slave twe_slave_i (.scl(scl_line), .sda(sda_line), .ack_en(ack_en),
      .sda_pull(sda_pull), .last_byte(last_byte), .stop_seen(stop_seen));
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // The request is held until ack is seen at an edge or 50 edges pass; then it is released.
   task automatic bus(input logic we, input logic [4:0] adr, input logic [7:0] dat);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wdat <= {24'h0, dat};
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_we <= 1'b0;
      chk("ack", 32'h1, {31'h0, wb_ack});
      @(posedge sys_clk);
   endtask : bus
   task automatic rdc(input string what, input logic [4:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 8'h00);
      chk(what, exp, rd);
   endtask : rdc
   task automatic wait_flag();
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[7] !== 1'b1 && n < 400) begin
         bus(1'b0, `TWE_OFS_CTRL, 8'h00);
         n++;
      end
      chk("flag", 32'h1, {31'h0, rd[7]});
   endtask : wait_flag
   initial begin
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rdc("ctrl", `TWE_OFS_CTRL, 32'h00);
      rdc("status", `TWE_OFS_STATUS, 32'hF8);
      rdc("data", `TWE_OFS_DATA, 32'hFF);
      rdc("own", `TWE_OFS_OWN, 32'h00);
      rdc("unmapped", 5'h10, 32'h00);
      bus(1'b1, `TWE_OFS_CTRL, 8'hA5);
      wait_flag();
      rdc("status start", `TWE_OFS_STATUS, 32'h08);
      chk("scl held", 32'h0, {31'h0, scl_line});
      chk("pin drive levels", 32'h0, {30'h0, scl_o, sda_o});
      chk("irq on", 32'h1, {31'h0, irq});
      bus(1'b1, `TWE_OFS_CTRL, 8'h25);
      bus(1'b0, `TWE_OFS_CTRL, 8'h00);
      chk("flag kept", 32'h1, {31'h0, rd[7]});
      rdc("status kept", `TWE_OFS_STATUS, 32'h08);
      chk("scl still held", 32'h0, {31'h0, scl_line});
      bus(1'b1, `TWE_OFS_DATA, 8'hA4);
      bus(1'b1, `TWE_OFS_CTRL, 8'h85);
      wait_flag();
      rdc("status addr ack", `TWE_OFS_STATUS, 32'h18);
      chk("address seen", 32'hA4, {24'h0, last_byte});
      cpu_gie <= 1'b0;
      rdc("status", `TWE_OFS_STATUS, 32'h18);
      chk("irq off", 32'h0, {31'h0, irq});
      ack_en <= 1'b0;
      bus(1'b1, `TWE_OFS_DATA, 8'h3C);
      bus(1'b1, `TWE_OFS_CTRL, 8'h85);
      wait_flag();
      rdc("status data nack", `TWE_OFS_STATUS, 32'h30);
      chk("data seen", 32'h3C, {24'h0, last_byte});
      bus(1'b1, `TWE_OFS_CTRL, 8'hA5);
      wait_flag();
      rdc("status rstart", `TWE_OFS_STATUS, 32'h10);
      bus(1'b1, `TWE_OFS_CTRL, 8'h95);
      for (int i = 0; i < 100 && stop_seen !== 1'b1; i++) begin
         @(posedge sys_clk);
      end
      chk("stop", 32'h1, {31'h0, stop_seen});
      repeat (3) bus(1'b0, `TWE_OFS_CTRL, 8'h00);
      chk("no flag after stop", 32'h0, {31'h0, rd[7]});
      rdc("status idle", `TWE_OFS_STATUS, 32'hF8);
      end_of_test();
   end
endmodule : tb
